//--- shared/wdp_pkg.sv
/*
  Constants shared by the watchdog unit: register addresses, field layout,
  restart sequence bytes, divider ratios and reset pulse length.
  Assumes nothing of its surroundings beyond an 8-bit special-function bus.
*/
package wdp_pkg;
    // Special-function addresses
    localparam logic [7:0] WDP_ADDR_RESTART = 8'ha6;
    localparam logic [7:0] WDP_ADDR_PERIOD  = 8'ha7;

    // Period register layout
    localparam int         WDP_TOSEL_W      = 3;
    localparam logic [2:0] WDP_TOSEL_RST    = 3'h0;
    localparam logic [4:0] WDP_PERIOD_RSVD  = 5'h00;

    // Two-byte restart sequence
    localparam logic [7:0] WDP_SEQ_FIRST    = 8'h1e;
    localparam logic [7:0] WDP_SEQ_SECOND   = 8'he1;

    // Structure of the count chain
    localparam int         WDP_PRESC_BITS   = 14;
    localparam int         WDP_COUNT_BITS   = 7;
    localparam int         WDP_PHASE_DIV    = 6;
    localparam int         WDP_CLK_HALF_DIV = 2;

    // Reset pulse, in oscillator periods
    localparam int         WDP_OSC_NS       = 10;
    localparam int         WDP_RST_PULSE_NS = 960;
    localparam int         WDP_RST_PULSE_CYC =
        (WDP_RST_PULSE_NS + WDP_OSC_NS - 1) / WDP_OSC_NS;

    // Restart sequence tracker states
    typedef enum logic [0:0] {
        WDP_SEQ_WAIT_FIRST,
        WDP_SEQ_WAIT_SECOND
    } wdp_seq_e;
endpackage

//--- shared/wdp_core_if.sv
/*
  Link between the watchdog register/control logic and its count chain.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface wdp_core_if;
    logic       enabled;    // Count chain may run
    logic       clear;      // Zero prescaler and counter
    logic       freeze;     // Hold every stage
    logic       half_rate;  // Watchdog clock is oscillator divided by two
    logic [2:0] tosel;      // Time-out select
    logic       overflow;   // One-cycle pulse at time-out

    modport ctrl (output enabled, output clear, output freeze, output half_rate,
                  output tosel, input overflow);
    modport core (input enabled, input clear, input freeze, input half_rate,
                  input tosel, output overflow);
endinterface

//--- src/wdp_core.sv
/*
  Watchdog count chain: clock divider, phase divider, prescaler and the
  programmable counter with its time-out compare.
  Assumes the control end drives every input of the interface each cycle.
*/
`timescale 1ns/1ns
module wdp_core
    import wdp_pkg::*;
#(
    parameter int PRESC_BITS = WDP_PRESC_BITS,
    parameter int COUNT_BITS = WDP_COUNT_BITS,
    parameter int PHASE_DIV  = WDP_PHASE_DIV
) (
    input  wire logic  clk_i,
    input  wire logic  rst_i,
    wdp_core_if.core   bus
);
    logic                  half_q;
    logic [3:0]            phase_q;
    logic [PRESC_BITS-1:0] presc_q;
    logic [COUNT_BITS-1:0] count_q;
    logic                  run;
    logic                  wd_tick;
    logic                  phase_end;
    logic                  presc_end;

    // Mask of counter bits used by a time-out select value
    function automatic logic [COUNT_BITS-1:0] tosel_mask(input logic [2:0] sel);
        logic [COUNT_BITS:0] one_hot;
        one_hot = '0;
        one_hot[sel] = 1'b1;
        return COUNT_BITS'(one_hot - 1'b1);
    endfunction

    // Freeze gates everything, so a held count resumes exactly where it stopped
    assign run       = bus.enabled && !bus.freeze && !bus.clear;
    assign wd_tick   = run && (!bus.half_rate || half_q);
    assign phase_end = wd_tick && (phase_q == 4'(PHASE_DIV - 1));
    assign presc_end = phase_end && (&presc_q);

    // Oscillator halving stage for the watchdog clock
    always_ff @(posedge clk_i) begin
        if (rst_i || bus.clear) begin
            half_q <= 1'b0;
        end else if (run) begin
            half_q <= !half_q;
        end
    end

    // Phase divider ahead of the prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i || bus.clear) begin
            phase_q <= '0;
        end else if (phase_end) begin
            phase_q <= '0;
        end else if (wd_tick) begin
            phase_q <= phase_q + 4'h1;
        end
    end

    // Prescaler
    always_ff @(posedge clk_i) begin
        if (rst_i || bus.clear) begin
            presc_q <= '0;
        end else if (phase_end) begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // Programmable counter; wraps on time-out
    always_ff @(posedge clk_i) begin
        if (rst_i || bus.clear) begin
            count_q <= '0;
        end else if (presc_end) begin
            if (count_q == tosel_mask(bus.tosel)) begin
                count_q <= '0;
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    assign bus.overflow = presc_end && (count_q == tosel_mask(bus.tosel));
endmodule // wdp_core

//--- src/wdp_top.sv
/*
  Watchdog unit top: special-function register access, restart sequence
  tracking, power-mode handling and the reset pulse on time-out.
  Assumes the core drives the special-function bus and power-mode levels
  synchronously to SYS_CLK_I, which is the oscillator clock.
*/
`timescale 1ns/1ns
module wdp_top
    import wdp_pkg::*;
#(
    parameter int PRESC_BITS = WDP_PRESC_BITS,
    parameter int COUNT_BITS = WDP_COUNT_BITS,
    parameter int PULSE_CYC  = WDP_RST_PULSE_CYC
) (
    input  wire logic       SYS_CLK_I,
    input  wire logic       RESET_I,
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic       SFR_WR_I,
    input  wire logic       SFR_RD_I,
    input  wire logic [7:0] SFR_WDATA_I,
    output logic      [7:0] SFR_RDATA_O,
    output logic            SFR_SEL_O,
    input  wire logic       IDLE_MODE_I,
    input  wire logic       POWER_DOWN_I,
    input  wire logic       WD_CLOCK_HALVING_I,
    input  wire logic       DOUBLE_SPEED_I,
    output logic            WD_ENABLED_O,
    output logic            WD_RESET_O
);
    // Register access: a write is taken on the rising edge that sees
    // SFR_WR_I high, and a read loads SFR_RDATA_O on the edge that sees
    // SFR_RD_I high; read data then stand until the next read. Strobes may
    // come back to back; writes to any other address change nothing, and reads there load zero.

    // Time-out: six watchdog-clock ticks make one prescaler step, a full
    // prescaler turn advances the counter, and the counter wraps at the
    // length picked by the time-out select. Power-down only holds the
    // chain; RESET_I, a completed restart pair or the reset pulse itself
    // are the only things that bring it back to zero.

    // Pulse counter sized from the pulse length, so a longer pulse cannot wrap
    localparam int PULSE_W = $clog2(PULSE_CYC + 1);

    // Address match, shared by the write, read and select decode
    function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // Link to the count chain
    wdp_core_if core_bus ();

    logic                 enabled_q;
    logic [2:0]           tosel_q;
    wdp_seq_e             seq_q;
    logic                 restart;
    logic                 wr_restart;
    logic                 wr_period;
    logic                 rd_period;
    logic [7:0]           rdata_q;
    logic                 pulse_q;
    logic [PULSE_W-1:0]   pulse_cnt_q;

    // Write decode; strobes to any other address leave the watchdog alone
    always_comb begin
        wr_restart = 1'b0;
        wr_period  = 1'b0;
        if (SFR_WR_I && sfr_hit(SFR_ADDR_I, WDP_ADDR_RESTART)) begin
            wr_restart = 1'b1;
        end else if (SFR_WR_I && sfr_hit(SFR_ADDR_I, WDP_ADDR_PERIOD)) begin
            wr_period = 1'b1;
        end
    end

    // Read decode; only the period register has anything to show
    always_comb begin
        rd_period = 1'b0;
        if (SFR_RD_I && sfr_hit(SFR_ADDR_I, WDP_ADDR_PERIOD)) begin
            rd_period = 1'b1;
        end
    end

    // Select is a plain address match so the core can steer its read mux early
    assign SFR_SEL_O = sfr_hit(SFR_ADDR_I, WDP_ADDR_RESTART)
                       || sfr_hit(SFR_ADDR_I, WDP_ADDR_PERIOD);

    // Restart sequence: 1Eh arms, E1h completes; any other byte disarms.
    // Tracking is kept apart from the enable so a stray byte from a runaway
    // program can neither start nor service the watchdog on its own.
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            seq_q <= WDP_SEQ_WAIT_FIRST;
        end else if (wr_restart) begin
            case (seq_q)
                WDP_SEQ_WAIT_FIRST: begin
                    if (SFR_WDATA_I == WDP_SEQ_FIRST) begin
                        seq_q <= WDP_SEQ_WAIT_SECOND;
                    end
                end
                WDP_SEQ_WAIT_SECOND: begin
                    // A repeated 1Eh simply starts a fresh sequence
                    if (SFR_WDATA_I == WDP_SEQ_FIRST) begin
                        seq_q <= WDP_SEQ_WAIT_SECOND;
                    end else begin
                        seq_q <= WDP_SEQ_WAIT_FIRST;
                    end
                end
                default: seq_q <= WDP_SEQ_WAIT_FIRST;
            endcase
        end
    end

    // A completed pair enables and clears the chain in the same edge; a
    // wrong byte only moves the tracker and never touches the count
    assign restart = wr_restart && (seq_q == WDP_SEQ_WAIT_SECOND)
                     && (SFR_WDATA_I == WDP_SEQ_SECOND);

    // Enable is sticky; only a chip reset drops it. A reset that ends
    // power-down takes the same path, so it also leaves the watchdog off
    // until software writes a fresh pair.
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            enabled_q <= 1'b0;
        end else if (restart) begin
            enabled_q <= 1'b1;
        end
    end

    // Time-out select; reserved bits are never stored, which costs nothing
    // and means they always read back as zero instead of stale values.
    // A new select takes effect at the next prescaler carry.
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            tosel_q <= WDP_TOSEL_RST;
        end else if (wr_period) begin
            tosel_q <= SFR_WDATA_I[WDP_TOSEL_W-1:0];
        end
    end

    // Read data; the restart register is write-only and reads zero, as do
    // addresses that do not belong to the watchdog
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            rdata_q <= 8'h00;
        end else if (SFR_RD_I) begin
            if (rd_period) begin
                rdata_q <= {WDP_PERIOD_RSVD, tosel_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // Held until the next read, so a slow core may pick it up late
    assign SFR_RDATA_O = rdata_q;

    // Reset pulse level; the chain is held clear while it stands, so a
    // further time-out during the pulse can neither shorten nor stretch it
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pulse_q <= 1'b0;
        end else if (core_bus.overflow) begin
            pulse_q <= 1'b1;
        end else if (pulse_q && pulse_cnt_q == '0) begin
            pulse_q <= 1'b0;
        end
    end

    // Pulse length counter, loaded at time-out and run down while high
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) begin
            pulse_cnt_q <= '0;
        end else if (core_bus.overflow) begin
            pulse_cnt_q <= PULSE_W'(PULSE_CYC - 1);
        end else if (pulse_q && pulse_cnt_q != '0) begin
            pulse_cnt_q <= pulse_cnt_q - 1'b1;
        end
    end

    // Both outputs come straight from flops, so neither can glitch
    assign WD_RESET_O   = pulse_q;
    assign WD_ENABLED_O = enabled_q;

    // Idle mode is deliberately not a gate: the chain keeps running there,
    // which is why software must keep servicing it while idle
    assign core_bus.enabled   = enabled_q && (IDLE_MODE_I || !IDLE_MODE_I);
    // Power-down freezes every stage; leaving it by an interrupt lets the
    // held count run on, leaving it by reset clears it through RESET_I
    assign core_bus.freeze    = POWER_DOWN_I;
    // A restart and the reset pulse both start the chain from zero
    assign core_bus.clear     = restart || pulse_q;
    // Halving wins over the speed mode; standard speed halves as well
    assign core_bus.half_rate = WD_CLOCK_HALVING_I || !DOUBLE_SPEED_I;
    assign core_bus.tosel     = tosel_q;

    // Count chain; shrinking PRESC_BITS shortens every time-out alike,
    // which keeps the ratios between select values intact
    wdp_core #(
        .PRESC_BITS (PRESC_BITS),
        .COUNT_BITS (COUNT_BITS),
        .PHASE_DIV  (WDP_PHASE_DIV)
    ) u_core (
        .clk_i (SYS_CLK_I),
        .rst_i (RESET_I),
        .bus   (core_bus.core)
    );
endmodule // wdp_top

//--- tb/wdp_chk.sv
/*
  Port checker for the watchdog top: bus answers, restart pairing,
  power-down hold and reset pulse length.
  Assumes one clock and the synchronous active-high chip reset.
*/
`timescale 1ns/1ns
module wdp_chk #(
    parameter int PULSE_CYC = 96
) (
    input wire logic       SYS_CLK_I,
    input wire logic       RESET_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic       SFR_WR_I,
    input wire logic       SFR_RD_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic       SFR_SEL_O,
    input wire logic       POWER_DOWN_I,
    input wire logic       WD_ENABLED_O,
    input wire logic       WD_RESET_O
);
    logic [7:0] pulse_q;
    logic [2:0] sel_q;

    // Cycles the reset pulse has stood so far
    always_ff @(posedge SYS_CLK_I) begin
        pulse_q <= (RESET_I || !WD_RESET_O) ? 8'h00 : pulse_q + 8'h01;
    end

    // Last time-out select written, so reads can be predicted
    always_ff @(posedge SYS_CLK_I) begin
        if (RESET_I) sel_q <= 3'h0;
        else if (SFR_WR_I && SFR_ADDR_I == 8'ha7) sel_q <= SFR_WDATA_I[2:0];
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (RESET_I);

    sequence s_first;
        SFR_WR_I && SFR_ADDR_I == 8'ha6 && SFR_WDATA_I == 8'h1e;
    endsequence
    sequence s_second;
        SFR_WR_I && SFR_ADDR_I == 8'ha6 && SFR_WDATA_I == 8'he1;
    endsequence

    chk_enable_pair: assert property (s_first ##1 s_second |=> WD_ENABLED_O)
        else $error("pair did not enable");
    chk_enable_cause: assert property ($rose(WD_ENABLED_O) |-> $past(SFR_WR_I) &&
        $past(SFR_WDATA_I) == 8'he1) else $error("enable without second byte");
    chk_enable_sticky: assert property (WD_ENABLED_O |=> WD_ENABLED_O)
        else $error("enable dropped without reset");
    chk_pd_hold: assert property (POWER_DOWN_I [*3] |-> !$rose(WD_RESET_O))
        else $error("time-out while frozen");
    chk_pulse_len: assert property ($fell(WD_RESET_O) |-> pulse_q == PULSE_CYC)
        else $error("reset pulse too short");
    chk_pulse_max: assert property (WD_RESET_O |-> pulse_q < PULSE_CYC)
        else $error("reset pulse too long");
    chk_pulse_enabled: assert property ($rose(WD_RESET_O) |-> WD_ENABLED_O)
        else $error("pulse while disabled");
    chk_period_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'ha7 |=>
        SFR_RDATA_O == {5'h00, $past(sel_q)}) else $error("period read wrong");
    chk_restart_read: assert property (SFR_RD_I && SFR_ADDR_I == 8'ha6 |=>
        SFR_RDATA_O == 8'h00) else $error("restart read not zero");
    chk_addr_select: assert property (SFR_SEL_O ==
        (SFR_ADDR_I == 8'ha6 || SFR_ADDR_I == 8'ha7)) else $error("select wrong");
endmodule // wdp_chk

bind wdp_top wdp_chk #(.PULSE_CYC(PULSE_CYC)) i_chk (
    .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .SFR_ADDR_I(SFR_ADDR_I),
    .SFR_WR_I(SFR_WR_I), .SFR_RD_I(SFR_RD_I), .SFR_WDATA_I(SFR_WDATA_I),
    .SFR_RDATA_O(SFR_RDATA_O), .SFR_SEL_O(SFR_SEL_O), .POWER_DOWN_I(POWER_DOWN_I),
    .WD_ENABLED_O(WD_ENABLED_O), .WD_RESET_O(WD_RESET_O));

//--- tb/tb_top.sv
/*
  Self-checking bench for the watchdog top through its register bus.
  Assumes a 100 MHz oscillator; the prescaler is shortened to keep runs brief.
*/
`timescale 1ns/1ns
module tb_top;
    import wdp_pkg::*;
    localparam int PB = 2;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic       idle = 1'b0, pd = 1'b0, half = 1'b0, dbl = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic [7:0] rdata;
    logic       sel, en, wdr;
    int         failures = 0, cmp_count = 0, n, e;
    logic [2:0] s_t [5] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h2};
    logic       h_t [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
    logic       d_t [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    int         p_t [5] = '{3000, 3000, 3000, 10, 3000};

    // Free-running oscillator
    initial forever #5 clk = ~clk;

    wdp_top #(.PRESC_BITS(PB)) i_dut (.SYS_CLK_I(clk), .RESET_I(rst), .SFR_ADDR_I(addr),
        .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata), .SFR_RDATA_O(rdata),
        .SFR_SEL_O(sel), .IDLE_MODE_I(idle), .POWER_DOWN_I(pd),
        .WD_CLOCK_HALVING_I(half), .DOUBLE_SPEED_I(dbl), .WD_ENABLED_O(en),
        .WD_RESET_O(wdr));

    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task do_reset;
        rst = 1'b1;
        repeat (12) @(negedge clk);
        rst = 1'b0;
    endtask

    // Single strobed access; the idle cycle after keeps strobes apart
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        @(negedge clk);
    endtask

    task rd_reg(input logic [7:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask

    // Back-to-back restart pair, as software issues it
    task restart;
        addr = 8'ha6;
        wdata = WDP_SEQ_FIRST;
        wr = 1'b1;
        @(negedge clk);
        wdata = WDP_SEQ_SECOND;
        @(negedge clk);
        wr = 1'b0;
    endtask

    // Running cycles to time-out; power-down cycles are not counted
    task tmo(input int pd_at, output int cnt);
        int k;
        cnt = 0;
        wdata = 8'h55;
        for (k = 0; k < 3000 && wdr !== 1'b1; k++) begin
            pd = (k >= pd_at && k < pd_at + 100);
            @(negedge clk);
            wr = (k == 4);
            if (!pd) cnt++;
        end
        pd = 1'b0;
        if (k == 3000) begin
            failures++;
            tally_and_finish;
        end
    endtask

    initial begin
        do_reset;
        rd_reg(8'h55, 8'h00);
        check(sel, 1'b0);
        rd_reg(8'ha6, 8'h00);
        check(sel, 1'b1);
        rd_reg(8'ha7, 8'h00);
        // A stray byte between the pair must not enable
        wr_reg(8'ha6, 8'h1e);
        wr_reg(8'ha6, 8'h55);
        wr_reg(8'ha6, 8'he1);
        check(en, 1'b0);
        repeat (300) @(negedge clk);
        check(wdr, 1'b0);
        // A repeated first byte re-arms, so the pair still completes
        wr_reg(8'ha6, 8'h1e);
        wr_reg(8'ha6, 8'h1e);
        wr_reg(8'ha6, 8'he1);
        check(en, 1'b1);
        for (int i = 0; i < 5; i++) begin
            do_reset;
            idle = (i == 0);
            half = h_t[i];
            dbl = d_t[i];
            wr_reg(8'ha7, {5'h00, s_t[i]});
            rd_reg(8'ha7, {5'h00, s_t[i]});
            restart;
            check(en, 1'b1);
            tmo(p_t[i], n);
            e = 6 * (1 << PB) * (1 << s_t[i]) * ((half || !dbl) ? 2 : 1);
            check(n >= e - 2 && n <= e + 3, 1'b1);
            for (n = 0; wdr === 1'b1 && n < 200; n++) @(negedge clk);
            check(n, 96);
            check(en, 1'b1);
        end
        // Servicing while idle keeps the reset pin quiet
        do_reset;
        idle = 1'b1;
        repeat (8) begin
            restart;
            repeat (15) @(negedge clk);
        end
        check(wdr, 1'b0);
        check(en, 1'b1);
        // Reset while powered down clears and disables
        idle = 1'b0;
        do_reset;
        restart;
        pd = 1'b1;
        repeat (5) @(negedge clk);
        do_reset;
        check(en, 1'b0);
        pd = 1'b0;
        repeat (300) @(negedge clk);
        check(wdr, 1'b0);
        tally_and_finish;
    end
endmodule // tb_top
